/* logic/ccr_cal_unit.sv */
// sequencer for one calibration: start, wait for trim, store, finish
`timescale 1ns/100ps
`default_nettype none
module ccr_cal_unit
(
    input  wire logic clock_i,
    input  wire logic nrst_i,
    ccr_cal_if.unit   cal
);

    typedef struct packed
    {
        ccr_pkg::ccr_cal_state_e state;
        logic [3:0]              result;
    } ccr_unit_s;

    ccr_unit_s st;
    ccr_unit_s next_st;

    //==========================================================================
    // next state
    always_comb
    begin
        next_st = st;
        unique case (st.state)
            ccr_pkg::CCR_IDLE:
            begin
                if (cal.start)
                begin
                    next_st.state = ccr_pkg::CCR_RUN;
                end
            end
            ccr_pkg::CCR_RUN:
            begin
                if (cal.trim_done)
                begin
                    next_st.result = cal.trim_result;
                    next_st.state  = ccr_pkg::CCR_LOAD;
                end
            end
            ccr_pkg::CCR_LOAD:
            begin
                // flag drops only after the store cycle [RL15]
                next_st.state = ccr_pkg::CCR_IDLE;
            end
            default:
            begin
                next_st.state = ccr_pkg::CCR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= '{state: ccr_pkg::CCR_IDLE, result: 4'h0};
        end
        else
        begin
            st <= next_st;
        end
    end

    //==========================================================================
    // outputs
    assign cal.busy     = (st.state != ccr_pkg::CCR_IDLE); // [RL1] [RL2]
    assign cal.trim_req = (st.state == ccr_pkg::CCR_RUN);
    assign cal.load     = (st.state == ccr_pkg::CCR_LOAD);
    assign cal.result   = st.result;

endmodule // ccr_cal_unit
`default_nettype wire

/* logic/ccr_regs.sv */
// calibration control and result registers with five calibration sequencers
`timescale 1ns/100ps
`default_nettype none
module ccr_regs
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    // register port
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    output logic      [7:0] reg_rdata_o,
    // analog trim engine, one lane per calibration flag bit
    output logic      [4:0] trim_req_o,
    input  wire logic [4:0] trim_done_i,
    input  wire logic [3:0] trim_result_i [5],
    // results delivered by the system calibration engine
    input  wire logic [4:0] res_load_i,
    input  wire logic [4:0] res_value_i,
    // trim values applied to the analog front end
    output logic      [4:0] ring_mismatch_result_o,
    output logic      [4:0] tip_mismatch_result_o,
    output logic      [4:0] differential_gain_result_o,
    output logic      [4:0] common_mode_gain_result_o,
    output logic      [3:0] current_limit_result_o,
    output logic      [3:0] monitor_offset_result_one_o,
    output logic      [3:0] monitor_offset_result_two_o,
    output logic            dac_offset_positive_o,
    output logic            dac_offset_negative_o,
    output logic            adc_offset_positive_o,
    output logic            adc_offset_negative_o,
    output logic      [3:0] balance_result_o
);

    //==========================================================================
    // state
    typedef struct packed
    {
        logic [4:0] ring;
        logic [4:0] tip;
        logic [4:0] diff;
        logic [4:0] cm;
        logic [3:0] ilim;
        logic [3:0] mon_one;
        logic [3:0] mon_two;
        logic       dac_pos;
        logic       dac_neg;
        logic       adc_pos;
        logic       adc_neg;
        logic [3:0] balance;
        logic [7:0] rdata;
    } ccr_regs_s;

    ccr_regs_s st;
    ccr_regs_s next_st;

    logic [4:0] cal_busy;
    logic [4:0] cal_load;
    logic [4:0] cal_start;
    logic [3:0] cal_result [5];

    //==========================================================================
    // address decode
    function automatic logic hit(input logic [7:0] addr, input logic [7:0] off);
        hit = (addr == off);
    endfunction

    //==========================================================================
    // calibration sequencers
    ccr_cal_if cal_if [ccr_pkg::CCR_NUM_CAL] ();

    genvar g;
    generate
        for (g = 0; g < ccr_pkg::CCR_NUM_CAL; g++)
        begin : g_cal
            assign cal_if[g].start       = cal_start[g];
            assign cal_if[g].trim_done   = trim_done_i[g];
            assign cal_if[g].trim_result = trim_result_i[g];
            assign cal_busy[g]           = cal_if[g].busy;
            assign cal_load[g]           = cal_if[g].load;
            assign cal_result[g]         = cal_if[g].result;
            assign trim_req_o[g]         = cal_if[g].trim_req;

            ccr_cal_unit u_unit
            (
                .clock_i (clock_i),
                .nrst_i  (nrst_i),
                .cal     (cal_if[g])
            );
        end
    endgenerate

    // a 1 starts an idle calibration; 0 or a repeat while busy is ignored
    always_comb
    begin
        cal_start = 5'h00;
        if (reg_wr_i && hit(reg_addr_i, ccr_pkg::CCR_OFF_CAL_CTRL_TWO))
        begin
            cal_start = reg_wdata_i[4:0] & ~cal_busy; // [RL3] [RL4] [RL5]
        end
    end

    //==========================================================================
    // register update and read data
    always_comb
    begin
        next_st = st;

        // software writes; upper bits dropped [RL14]
        if (reg_wr_i)
        begin
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_RING_RESULT))
            begin
                next_st.ring = reg_wdata_i[4:0]; // [RL6]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_TIP_RESULT))
            begin
                next_st.tip = reg_wdata_i[4:0]; // [RL7]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_DIFF_RESULT))
            begin
                next_st.diff = reg_wdata_i[4:0]; // [RL8]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_CM_RESULT))
            begin
                next_st.cm = reg_wdata_i[4:0]; // [RL9]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_ILIM_RESULT))
            begin
                next_st.ilim = reg_wdata_i[3:0]; // [RL10]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_MON_RESULT))
            begin
                next_st.mon_one = reg_wdata_i[ccr_pkg::CCR_MON_ONE_LSB +: 4]; // [RL11]
                next_st.mon_two = reg_wdata_i[ccr_pkg::CCR_MON_TWO_LSB +: 4]; // [RL11]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_OFFSET_POL))
            begin
                next_st.dac_pos = reg_wdata_i[ccr_pkg::CCR_DAC_POS_BIT]; // [RL12]
                next_st.dac_neg = reg_wdata_i[ccr_pkg::CCR_DAC_NEG_BIT]; // [RL12]
                next_st.adc_pos = reg_wdata_i[ccr_pkg::CCR_ADC_POS_BIT]; // [RL13]
                next_st.adc_neg = reg_wdata_i[ccr_pkg::CCR_ADC_NEG_BIT]; // [RL13]
            end
        end

        // hardware results win over a software write in the same cycle
        if (res_load_i[ccr_pkg::CCR_RES_RING])
        begin
            next_st.ring = res_value_i;
        end
        if (res_load_i[ccr_pkg::CCR_RES_TIP])
        begin
            next_st.tip = res_value_i;
        end
        if (res_load_i[ccr_pkg::CCR_RES_DIFF])
        begin
            next_st.diff = res_value_i;
        end
        if (res_load_i[ccr_pkg::CCR_RES_CM])
        begin
            next_st.cm = res_value_i;
        end
        if (res_load_i[ccr_pkg::CCR_RES_ILIM])
        begin
            next_st.ilim = res_value_i[3:0];
        end

        // store results while the flag still reads 1 [RL15]
        if (cal_load[ccr_pkg::CCR_CAL_MON_ONE])
        begin
            next_st.mon_one = cal_result[ccr_pkg::CCR_CAL_MON_ONE];
        end
        if (cal_load[ccr_pkg::CCR_CAL_MON_TWO])
        begin
            next_st.mon_two = cal_result[ccr_pkg::CCR_CAL_MON_TWO];
        end
        if (cal_load[ccr_pkg::CCR_CAL_DAC])
        begin
            next_st.dac_pos = cal_result[ccr_pkg::CCR_CAL_DAC][1];
            next_st.dac_neg = cal_result[ccr_pkg::CCR_CAL_DAC][0];
        end
        if (cal_load[ccr_pkg::CCR_CAL_ADC])
        begin
            next_st.adc_pos = cal_result[ccr_pkg::CCR_CAL_ADC][1];
            next_st.adc_neg = cal_result[ccr_pkg::CCR_CAL_ADC][0];
        end
        if (cal_load[ccr_pkg::CCR_CAL_BALANCE])
        begin
            next_st.balance = cal_result[ccr_pkg::CCR_CAL_BALANCE];
        end

        // read data, reserved bits zero [RL14]
        if (reg_rd_i)
        begin
            next_st.rdata = 8'h00;
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_CAL_CTRL_TWO))
            begin
                next_st.rdata = {3'h0, cal_busy}; // [RL1] [RL2]
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_RING_RESULT))
            begin
                next_st.rdata = {3'h0, st.ring};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_TIP_RESULT))
            begin
                next_st.rdata = {3'h0, st.tip};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_DIFF_RESULT))
            begin
                next_st.rdata = {3'h0, st.diff};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_CM_RESULT))
            begin
                next_st.rdata = {3'h0, st.cm};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_ILIM_RESULT))
            begin
                next_st.rdata = {4'h0, st.ilim};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_MON_RESULT))
            begin
                next_st.rdata = {st.mon_one, st.mon_two};
            end
            if (hit(reg_addr_i, ccr_pkg::CCR_OFF_OFFSET_POL))
            begin
                next_st.rdata = {4'h0, st.dac_pos, st.dac_neg, st.adc_pos, st.adc_neg};
            end
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            st <= '{ring:    ccr_pkg::CCR_RST_RING,
                    tip:     ccr_pkg::CCR_RST_TIP,
                    diff:    ccr_pkg::CCR_RST_DIFF,
                    cm:      ccr_pkg::CCR_RST_CM,
                    ilim:    ccr_pkg::CCR_RST_ILIM,
                    mon_one: ccr_pkg::CCR_RST_MON,
                    mon_two: ccr_pkg::CCR_RST_MON,
                    dac_pos: ccr_pkg::CCR_RST_POL,
                    dac_neg: ccr_pkg::CCR_RST_POL,
                    adc_pos: ccr_pkg::CCR_RST_POL,
                    adc_neg: ccr_pkg::CCR_RST_POL,
                    balance: ccr_pkg::CCR_RST_BALANCE,
                    rdata:   8'h00};
        end
        else
        begin
            st <= next_st;
        end
    end

    //==========================================================================
    // outputs
    assign reg_rdata_o                 = st.rdata;
    assign ring_mismatch_result_o      = st.ring;
    assign tip_mismatch_result_o       = st.tip;
    assign differential_gain_result_o  = st.diff;
    assign common_mode_gain_result_o   = st.cm;
    assign current_limit_result_o      = st.ilim;
    assign monitor_offset_result_one_o = st.mon_one;
    assign monitor_offset_result_two_o = st.mon_two;
    assign dac_offset_positive_o       = st.dac_pos;
    assign dac_offset_negative_o       = st.dac_neg;
    assign adc_offset_positive_o       = st.adc_pos;
    assign adc_offset_negative_o       = st.adc_neg;
    assign balance_result_o            = st.balance;

endmodule // ccr_regs
`default_nettype wire

/* pkg/ccr_cal_if.sv */
// carrier between the register group and one calibration unit
`timescale 1ns/100ps
`default_nettype none
interface ccr_cal_if;
    logic       start;
    logic       trim_done;
    logic [3:0] trim_result;
    logic       busy;
    logic       trim_req;
    logic       load;
    logic [3:0] result;

    modport unit
    (
        input  start,
        input  trim_done,
        input  trim_result,
        output busy,
        output trim_req,
        output load,
        output result
    );

    modport ctrl
    (
        output start,
        output trim_done,
        output trim_result,
        input  busy,
        input  trim_req,
        input  load,
        input  result
    );
endinterface
`default_nettype wire

/* pkg/ccr_pkg.sv */
// constants and types of the calibration control and result register group
//==============================================================================
// How it works
// RL1: each calibration flag, bits 4 to 0, reads 1 while enabled or running.
// RL2: each calibration flag reads 0 when idle and returns to 0 when done.
// RL3: writing 1 to bit 2 starts the audio DAC offset calibration.
// RL4: writing 1 to bit 1 starts the audio ADC offset calibration.
// RL5: writing 1 to bit 0 starts the longitudinal balance calibration.
// RL6: ring mismatch result is read/write bits 4:0, reset 0001_0000.
// RL7: tip mismatch result is read/write bits 4:0 in its own register.
// RL8: differential gain result is read/write bits 4:0, upper bits reserved.
// RL9: common-mode gain result is read/write bits 4:0, reset 0001_0001.
// RL10: current limit result is read/write bits 3:0, reset 0000_1000.
// RL11: monitor offset results share a register: one in 7:4, two in 3:0.
// RL12: DAC offset positive and negative bits sit at 3 and 2, reset zero.
// RL13: ADC offset positive and negative bits sit at 1 and 0.
// RL14: reserved bits read zero and ignore writes.
// RL15: a finished calibration stores its result before its flag clears.
//==============================================================================
`default_nettype none
package ccr_pkg;

    //==========================================================================
    // register offsets
    localparam logic [7:0] CCR_OFF_CAL_CTRL_TWO = 8'h61;
    localparam logic [7:0] CCR_OFF_RING_RESULT  = 8'h62;
    localparam logic [7:0] CCR_OFF_TIP_RESULT   = 8'h63;
    localparam logic [7:0] CCR_OFF_DIFF_RESULT  = 8'h64;
    localparam logic [7:0] CCR_OFF_CM_RESULT    = 8'h65;
    localparam logic [7:0] CCR_OFF_ILIM_RESULT  = 8'h66;
    localparam logic [7:0] CCR_OFF_MON_RESULT   = 8'h67;
    localparam logic [7:0] CCR_OFF_OFFSET_POL   = 8'h68;

    //==========================================================================
    // field positions and widths
    localparam int CCR_NUM_CAL       = 5;
    localparam int CCR_CAL_MON_ONE   = 4;
    localparam int CCR_CAL_MON_TWO   = 3;
    localparam int CCR_CAL_DAC       = 2;
    localparam int CCR_CAL_ADC       = 1;
    localparam int CCR_CAL_BALANCE   = 0;
    localparam int CCR_GAIN_W        = 5;
    localparam int CCR_NIB_W         = 4;
    localparam int CCR_MON_ONE_LSB   = 4;
    localparam int CCR_MON_TWO_LSB   = 0;
    localparam int CCR_DAC_POS_BIT   = 3;
    localparam int CCR_DAC_NEG_BIT   = 2;
    localparam int CCR_ADC_POS_BIT   = 1;
    localparam int CCR_ADC_NEG_BIT   = 0;
    localparam int CCR_RES_RING      = 4;
    localparam int CCR_RES_TIP       = 3;
    localparam int CCR_RES_DIFF      = 2;
    localparam int CCR_RES_CM        = 1;
    localparam int CCR_RES_ILIM      = 0;

    //==========================================================================
    // reset values
    localparam logic [4:0] CCR_RST_RING    = 5'h10;
    localparam logic [4:0] CCR_RST_TIP     = 5'h10;
    localparam logic [4:0] CCR_RST_DIFF    = 5'h00;
    localparam logic [4:0] CCR_RST_CM      = 5'h11;
    localparam logic [3:0] CCR_RST_ILIM    = 4'h8;
    localparam logic [3:0] CCR_RST_MON     = 4'h0;
    localparam logic [3:0] CCR_RST_BALANCE = 4'h0;
    localparam logic       CCR_RST_POL     = 1'b0;

    //==========================================================================
    // calibration unit states
    typedef enum logic [1:0]
    {
        CCR_IDLE = 2'b00,
        CCR_RUN  = 2'b01,
        CCR_LOAD = 2'b10
    } ccr_cal_state_e;

endpackage
`default_nettype wire

/* tb/ccr_regs_sva.sv */
// assertions on the calibration control and result register ports
`timescale 1ns/100ps
`default_nettype none
module ccr_regs_sva
(
    input  wire logic       clock_i,
    input  wire logic       nrst_i,
    input  wire logic       reg_wr_i,
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic [7:0] reg_rdata_o,
    input  wire logic [4:0] trim_req_o,
    input  wire logic [4:0] trim_done_i,
    input  wire logic [3:0] trim_result_i [5],
    input  wire logic [4:0] res_load_i,
    input  wire logic [4:0] res_value_i,
    input  wire logic [4:0] ring_mismatch_result_o,
    input  wire logic [3:0] current_limit_result_o,
    input  wire logic       dac_offset_positive_o,
    input  wire logic       dac_offset_negative_o
);
    //==========
    // sequences
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);

    // write of 1 to an idle lane
    sequence start_s(int k);
        reg_wr_i && reg_addr_i == 8'h61 && reg_wdata_i[k] && !trim_req_o[k]
            && !$past(trim_req_o[k]);
    endsequence
    sequence dac_done_s;
        trim_req_o[2] && trim_done_i[2];
    endsequence
    sequence ctrl_rd_s;
        reg_rd_i && reg_addr_i == 8'h61;
    endsequence

    //==========
    // assertions
    start_dac_a:
        assert property (start_s(2) |=> trim_req_o[2]) else $error("dac cal not started");
    start_adc_a:
        assert property (start_s(1) |=> trim_req_o[1]) else $error("adc cal not started");
    start_bal_a:
        assert property (start_s(0) |=> trim_req_o[0]) else $error("balance cal not started");
    flag_busy_a:
        assert property (trim_req_o[1] && reg_rd_i && reg_addr_i == 8'h61 |=> reg_rdata_o[1])
            else $error("busy flag reads 0");
    flag_clear_a:
        assert property (dac_done_s ##2 ctrl_rd_s |=> !reg_rdata_o[2])
            else $error("flag not cleared after calibration");
    store_first_a:
        assert property (dac_done_s |=> !trim_req_o[2] ##1
            (dac_offset_positive_o == $past(trim_result_i[2][1], 2)
            && dac_offset_negative_o == $past(trim_result_i[2][0], 2)))
            else $error("dac result not stored");
    unmapped_zero_a:
        assert property (reg_rd_i && !(reg_addr_i inside {[8'h61:8'h68]})
            |=> reg_rdata_o == 8'h00) else $error("unmapped read not zero");
    reserved_zero_a:
        assert property (reg_rd_i && reg_addr_i inside {[8'h61:8'h65]}
            |=> reg_rdata_o[7:5] == 3'h0) else $error("reserved bits not zero");
    ring_load_a:
        assert property (res_load_i[4] |=> ring_mismatch_result_o == $past(res_value_i))
            else $error("ring result not loaded");
    ilim_write_a:
        assert property (reg_wr_i && reg_addr_i == 8'h66 && !res_load_i[0]
            |=> current_limit_result_o == $past(reg_wdata_i[3:0]))
            else $error("current limit write lost");
    dac_write_a:
        assert property (reg_wr_i && reg_addr_i == 8'h68 && !$past(trim_req_o[2])
            |=> dac_offset_positive_o == $past(reg_wdata_i[3])
            && dac_offset_negative_o == $past(reg_wdata_i[2]))
            else $error("dac offset write lost");
endmodule // ccr_regs_sva

bind ccr_regs ccr_regs_sva u_sva
(
    .clock_i(clock_i), .nrst_i(nrst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .trim_req_o(trim_req_o), .trim_done_i(trim_done_i), .trim_result_i(trim_result_i),
    .res_load_i(res_load_i), .res_value_i(res_value_i),
    .ring_mismatch_result_o(ring_mismatch_result_o),
    .current_limit_result_o(current_limit_result_o),
    .dac_offset_positive_o(dac_offset_positive_o),
    .dac_offset_negative_o(dac_offset_negative_o)
);
`default_nettype wire

/* tb/testbench.sv */
// self-checking bench of the calibration control and result registers
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic       clock;
    logic       nrst;
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [4:0] trim_req;
    logic [4:0] trim_done;
    logic [3:0] trim_result [5];
    logic [4:0] res_load;
    logic [4:0] res_value;
    logic [4:0] ring;
    logic [4:0] tip;
    logic [4:0] diff;
    logic [4:0] cm;
    logic [3:0] ilim;
    logic [3:0] mon_one;
    logic [3:0] mon_two;
    logic       dac_p;
    logic       dac_n;
    logic       adc_p;
    logic       adc_n;
    logic [3:0] balance;
    logic [7:0] got;
    int         error_cnt;
    int         n_checks;
    int         cycles;

    ccr_regs DUT
    (
        .clock_i(clock), .nrst_i(nrst), .reg_wr_i(wr), .reg_rd_i(rd), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_rdata_o(rdata), .trim_req_o(trim_req),
        .trim_done_i(trim_done), .trim_result_i(trim_result), .res_load_i(res_load),
        .res_value_i(res_value), .ring_mismatch_result_o(ring), .tip_mismatch_result_o(tip),
        .differential_gain_result_o(diff), .common_mode_gain_result_o(cm),
        .current_limit_result_o(ilim), .monitor_offset_result_one_o(mon_one),
        .monitor_offset_result_two_o(mon_two), .dac_offset_positive_o(dac_p),
        .dac_offset_negative_o(dac_n), .adc_offset_positive_o(adc_p),
        .adc_offset_negative_o(adc_n), .balance_result_o(balance)
    );

    //==========
    // clock and watchdog
    always #20 clock = ~clock;

    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            error_cnt++;
            stop_test();
        end
    end

    //==========
    // shared tasks
    task automatic chk(input logic [7:0] got_v, input logic [7:0] exp_v);
        n_checks++;
        if (got_v !== exp_v)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got_v, exp_v);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        wr    = 1'b1;
        addr  = a;
        wdata = d;
        @(negedge clock);
        wr    = 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a);
        @(negedge clock);
        rd   = 1'b1;
        addr = a;
        @(negedge clock);
        rd   = 1'b0;
        got  = rdata;
    endtask

    task automatic pulse(input logic [4:0] lanes);
        @(negedge clock);
        trim_done = lanes;
        @(negedge clock);
        trim_done = 5'h00;
    endtask

    task automatic stop_test();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    //==========
    // scenarios
    task automatic test_reset();
        logic [7:0] exp_v [10];
        exp_v = '{8'h00, 8'h00, 8'h10, 8'h10, 8'h00, 8'h11, 8'h08, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 10; i++)
        begin
            reg_rd(8'h60 + 8'(i));
            chk(got, exp_v[i]);
        end
        chk({3'h0, ring}, 8'h10);
        $display("test reset values done");
    endtask

    task automatic test_fields();
        logic [7:0] exp_v [8];
        exp_v = '{8'h1F, 8'h1F, 8'h1F, 8'h1F, 8'h0F, 8'hFF, 8'h0F, 8'h00};
        for (int i = 0; i < 8; i++)
        begin
            reg_wr(8'h62 + 8'(i), 8'hFF);
            reg_rd(8'h62 + 8'(i));
            chk(got, exp_v[i]);
        end
        chk({mon_one, mon_two}, 8'hFF);
        chk({4'h0, dac_p, dac_n, adc_p, adc_n}, 8'h0F);
        for (int i = 0; i < 7; i++)
        begin
            reg_wr(8'h62 + 8'(i), 8'h00);
            reg_rd(8'h62 + 8'(i));
            chk(got, 8'h00);
        end
        $display("test field access done");
    endtask

    task automatic test_hw_load();
        for (int i = 0; i < 5; i++)
        begin
            @(negedge clock);
            res_load  = 5'h10 >> i;
            res_value = 5'h15;
            wr        = 1'b1;
            addr      = 8'h62 + 8'(i);
            wdata     = 8'h03;
            @(negedge clock);
            res_load  = 5'h00;
            wr        = 1'b0;
            reg_rd(8'h62 + 8'(i));
            chk(got, (i == 4) ? 8'h05 : 8'h15);
        end
        chk({3'h0, ring}, 8'h15);
        chk({3'h0, tip}, 8'h15);
        chk({3'h0, diff}, 8'h15);
        chk({3'h0, cm}, 8'h15);
        chk({4'h0, ilim}, 8'h05);
        $display("test result load done");
    endtask

    task automatic test_single_cal();
        reg_wr(8'h61, 8'h04);
        reg_rd(8'h61);
        chk(got, 8'h04);
        chk({3'h0, trim_req}, 8'h04);
        reg_wr(8'h61, 8'h00);
        reg_rd(8'h61);
        chk(got, 8'h04);
        pulse(5'h04);
        reg_rd(8'h61);
        chk(got, 8'h00);
        chk({4'h0, dac_p, dac_n, adc_p, adc_n}, 8'h08);
        chk({3'h0, trim_req}, 8'h00);
        $display("test single calibration done");
    endtask

    task automatic test_all_cal();
        reg_wr(8'h61, 8'h1F);
        reg_rd(8'h61);
        chk(got, 8'h1F);
        chk({3'h0, trim_req}, 8'h1F);
        pulse(5'h1F);
        reg_rd(8'h61);
        chk(got, 8'h00);
        reg_rd(8'h67);
        chk(got, 8'hA5);
        reg_rd(8'h68);
        chk(got, 8'h09);
        chk({4'h0, balance}, 8'h09);
        $display("test all calibrations done");
    endtask

    //==========
    // main sequence
    initial
    begin
        clock       = 1'b0;
        nrst        = 1'b0;
        wr          = 1'b0;
        rd          = 1'b0;
        addr        = 8'h00;
        wdata       = 8'h00;
        trim_done   = 5'h00;
        res_load    = 5'h00;
        res_value   = 5'h00;
        error_cnt   = 0;
        n_checks    = 0;
        cycles      = 0;
        trim_result = '{4'h9, 4'h1, 4'h2, 4'h5, 4'hA};
        repeat (2) @(negedge clock);
        nrst = 1'b1;
        test_reset();
        test_fields();
        test_hw_load();
        test_single_cal();
        test_all_cal();
        stop_test();
    end
endmodule // testbench
`default_nettype wire
